// ===== hw/epml_pkg.sv
/*
  Constants for the execution priority mask logic: register offsets, field
  positions, reset values and the signed priority encoding.
  Assumes a 10-bit two's complement priority, where a lower number wins.
*/
package epml_pkg;

  localparam int          PRIO_W        = 10;
  typedef logic signed [PRIO_W-1:0] epml_prio_t;

  // Priority levels used by the boosts
  localparam epml_prio_t  PRIO_NEG3     = -10'sd3;
  localparam epml_prio_t  PRIO_NEG1     = -10'sd1;
  localparam epml_prio_t  PRIO_ZERO     = 10'sh000;
  localparam epml_prio_t  PRIO_HALF     = 10'sh080;
  localparam epml_prio_t  PRIO_IDLE     = 10'sh100;

  // Implemented upper bits of the threshold field; low bits read zero
  localparam logic [7:0]  THR_IMPL_MASK = 8'he0;
  localparam logic [7:0]  THR_HALF_BIT  = 8'h80;

  // Register byte offsets
  localparam logic [7:0]  OFS_FEM_S     = 8'h00;
  localparam logic [7:0]  OFS_FEM_NS    = 8'h04;
  localparam logic [7:0]  OFS_BPT_S     = 8'h08;
  localparam logic [7:0]  OFS_BPT_NS    = 8'h0c;
  localparam logic [7:0]  OFS_CFG       = 8'h10;
  localparam logic [7:0]  OFS_STAT      = 8'h14;

  // Configuration and fault escalation mask register fields
  localparam int          CFG_SEC_EXT   = 0;
  localparam int          CFG_NS_FAULT  = 1;
  localparam int          CFG_SEC_PRIO  = 2;
  localparam int          FEM_BIT       = 0;

  // Status register fields
  localparam int          STAT_FAULT_ON = 16;
  localparam int          STAT_BASE_ON  = 17;

  // Reset values
  localparam logic        FEM_RST       = 1'b0;
  localparam logic [7:0]  BPT_RST       = 8'h00;
  localparam logic [2:0]  CFG_RST       = 3'h0;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int          HTRANS_ACT    = 1;

  // Numerically lower of two priorities, the higher in urgency
  function automatic epml_prio_t prio_min(input epml_prio_t a, input epml_prio_t b);
    prio_min = (a < b) ? a : b;
  endfunction : prio_min

endpackage : epml_pkg

// ===== hw/epml_boost_calc.sv
/*
  Works out the boosted levels of the fault escalation mask and of the base
  priority threshold from the mask copies and the two system controls.
  Assumes all inputs come from flip-flops in the same clock domain.
*/
`timescale 1ns/100ps
module epml_boost_calc (
  // Configuration
  input  wire logic                sec_ext_en,
  input  wire logic                nonsecure_fault_targeting_control,
  input  wire logic                secure_prioritization_control,
  // Mask copies
  input  wire logic                secure_fault_escalation_copy,
  input  wire logic                nonsecure_fault_escalation_copy,
  input  wire logic [7:0]          base_priority_threshold,
  input  wire logic [7:0]          nonsecure_base_threshold_copy,
  // Results
  output logic                     fault_boost_on,
  output epml_pkg::epml_prio_t     fault_boost_prio,
  output logic                     base_boost_on,
  output epml_pkg::epml_prio_t     base_boost_prio
);

  epml_pkg::epml_prio_t s_lvl;
  epml_pkg::epml_prio_t ns_lvl;
  epml_pkg::epml_prio_t bs_lvl;
  epml_pkg::epml_prio_t bns_lvl;
  logic [7:0]           ns_mapped;

  always_comb begin
    s_lvl  = epml_pkg::PRIO_IDLE;
    ns_lvl = epml_pkg::PRIO_IDLE;
    if (!sec_ext_en) begin
      if (secure_fault_escalation_copy) begin
        s_lvl = epml_pkg::PRIO_NEG1;                               // RULE_01
      end
    end else if (!nonsecure_fault_targeting_control) begin
      if (secure_fault_escalation_copy) begin
        s_lvl = epml_pkg::PRIO_NEG1;                               // RULE_02
      end
      if (nonsecure_fault_escalation_copy) begin
        ns_lvl = secure_prioritization_control ? epml_pkg::PRIO_HALF // RULE_04
                                               : epml_pkg::PRIO_ZERO; // RULE_03
      end
    end else begin
      if (secure_fault_escalation_copy) begin
        s_lvl = epml_pkg::PRIO_NEG3;                               // RULE_05
      end
      if (nonsecure_fault_escalation_copy) begin
        ns_lvl = epml_pkg::PRIO_NEG1;                              // RULE_05
      end
    end
    fault_boost_prio = epml_pkg::prio_min(s_lvl, ns_lvl);
    fault_boost_on   = (fault_boost_prio != epml_pkg::PRIO_IDLE);
  end

  // Nonsecure threshold lands in the bottom half of the range
  assign ns_mapped = (nonsecure_base_threshold_copy >> 1) | epml_pkg::THR_HALF_BIT; // RULE_08

  always_comb begin
    bs_lvl  = epml_pkg::PRIO_IDLE;
    bns_lvl = epml_pkg::PRIO_IDLE;
    if (base_priority_threshold != 8'h00) begin                   // RULE_10
      bs_lvl = epml_pkg::epml_prio_t'({2'b00, base_priority_threshold}); // RULE_07
    end
    if (sec_ext_en && nonsecure_base_threshold_copy != 8'h00) begin // RULE_10
      bns_lvl = epml_pkg::epml_prio_t'({2'b00, ns_mapped});        // RULE_08
    end
    base_boost_prio = epml_pkg::prio_min(bs_lvl, bns_lvl);
    base_boost_on   = (base_boost_prio != epml_pkg::PRIO_IDLE);
  end

endmodule : epml_boost_calc

// ===== hw/epml_top.sv
/*
  Execution priority mask logic: fault escalation mask copies, base priority
  threshold copies and system controls behind an AHB-Lite slave; forms the
  current execution priority and masks candidate exceptions.
  Assumes one clock, a single slave on the bus, and priorities given as
  10-bit two's complement numbers where lower means more urgent.
*/
// Implementation choices: register access over AHB-Lite and the placing of the registers.
// Summary of operation
// RULE_01 - Without security, one mask bit boosts to -1
// RULE_02 - Targeting zero: secure copy boosts to -1
// RULE_03 - Targeting zero, prioritization zero: nonsecure to 0x0
// RULE_04 - Targeting zero, prioritization one: nonsecure to 0x80
// RULE_05 - Targeting one: secure to -3, nonsecure -1
// RULE_06 - Fault boost masks lower or equal priorities
// RULE_07 - Threshold in bits 7:0, upper bits read zero
// RULE_08 - Nonsecure threshold mapped into bottom half
// RULE_09 - Threshold masks only strictly lower priorities
// RULE_10 - Threshold of zero disables base boosting
// RULE_11 - Unimplemented low threshold bits read zero
// RULE_12 - Higher numbers mean lower exception priority
// RULE_13 - Execution priority is lowest of all boosts
`timescale 1ns/100ps
module epml_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Exception arbitration
  input  wire logic                active_exc_valid,
  input  wire epml_pkg::epml_prio_t active_exc_prio,
  input  wire epml_pkg::epml_prio_t cand_exc_prio,
  output logic                     cand_exc_masked,
  output epml_pkg::epml_prio_t     cur_exec_prio
);

  // Mask registers and controls
  logic                 fem_s_ff;
  logic                 fem_ns_ff;
  logic [7:0]           bpt_s_ff;
  logic [7:0]           bpt_ns_ff;
  logic [2:0]           cfg_ff;

  // Bus data phase state
  logic                 wr_pend_ff;
  logic                 rd_pend_ff;
  logic                 rd_wait_ff;
  logic [7:0]           addr_ff;
  logic [31:0]          hrdata_ff;
  logic                 addr_take;

  // Priority results
  logic                 fault_on;
  epml_pkg::epml_prio_t fault_prio;
  logic                 base_on;
  epml_pkg::epml_prio_t base_prio;
  epml_pkg::epml_prio_t exc_prio;
  epml_pkg::epml_prio_t nxt_cur_prio;
  epml_pkg::epml_prio_t cur_prio_ff;
  logic                 nxt_masked;
  logic                 masked_ff;
  logic [31:0]          rd_mux;

  epml_boost_calc u_boost (
    .sec_ext_en                        (cfg_ff[epml_pkg::CFG_SEC_EXT]),
    .nonsecure_fault_targeting_control (cfg_ff[epml_pkg::CFG_NS_FAULT]),
    .secure_prioritization_control     (cfg_ff[epml_pkg::CFG_SEC_PRIO]),
    .secure_fault_escalation_copy      (fem_s_ff),
    .nonsecure_fault_escalation_copy   (fem_ns_ff),
    .base_priority_threshold           (bpt_s_ff),
    .nonsecure_base_threshold_copy     (bpt_ns_ff),
    .fault_boost_on                    (fault_on),
    .fault_boost_prio                  (fault_prio),
    .base_boost_on                     (base_on),
    .base_boost_prio                   (base_prio)
  );

  // Address phase accepted
  assign addr_take = hsel & htrans[epml_pkg::HTRANS_ACT] & hready;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= addr_take & hwrite;
      rd_pend_ff <= addr_take & ~hwrite;
      if (addr_take) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so that the read data can be registered in hrdata_ff
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_wait_ff <= 1'b0;
    end else begin
      rd_wait_ff <= rd_pend_ff & ~rd_wait_ff;
    end
  end

  assign hreadyout = ~(rd_pend_ff & ~rd_wait_ff);
  assign hresp     = 1'b0;

  // Register writes in the data phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fem_s_ff  <= epml_pkg::FEM_RST;
      fem_ns_ff <= epml_pkg::FEM_RST;
      bpt_s_ff  <= epml_pkg::BPT_RST;
      bpt_ns_ff <= epml_pkg::BPT_RST;
      cfg_ff    <= epml_pkg::CFG_RST;
    end else if (wr_pend_ff) begin
      if (addr_ff == epml_pkg::OFS_FEM_S) begin
        fem_s_ff <= hwdata[epml_pkg::FEM_BIT];                   // RULE_01
      end else if (addr_ff == epml_pkg::OFS_FEM_NS) begin
        fem_ns_ff <= hwdata[epml_pkg::FEM_BIT];
      end else if (addr_ff == epml_pkg::OFS_BPT_S) begin
        bpt_s_ff <= hwdata[7:0] & epml_pkg::THR_IMPL_MASK;      // RULE_11
      end else if (addr_ff == epml_pkg::OFS_BPT_NS) begin
        bpt_ns_ff <= hwdata[7:0] & epml_pkg::THR_IMPL_MASK;     // RULE_11
      end else if (addr_ff == epml_pkg::OFS_CFG) begin
        cfg_ff <= hwdata[2:0];
      end
    end
  end

  // Read multiplexer; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ff == epml_pkg::OFS_FEM_S) begin
      rd_mux[epml_pkg::FEM_BIT] = fem_s_ff;
    end else if (addr_ff == epml_pkg::OFS_FEM_NS) begin
      rd_mux[epml_pkg::FEM_BIT] = fem_ns_ff;
    end else if (addr_ff == epml_pkg::OFS_BPT_S) begin
      rd_mux[7:0] = bpt_s_ff;                                    // RULE_07
    end else if (addr_ff == epml_pkg::OFS_BPT_NS) begin
      rd_mux[7:0] = bpt_ns_ff;                                   // RULE_07
    end else if (addr_ff == epml_pkg::OFS_CFG) begin
      rd_mux[2:0] = cfg_ff;
    end else if (addr_ff == epml_pkg::OFS_STAT) begin
      rd_mux[epml_pkg::PRIO_W-1:0]     = cur_prio_ff;
      rd_mux[epml_pkg::STAT_FAULT_ON] = fault_on;
      rd_mux[epml_pkg::STAT_BASE_ON]  = base_on;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff & ~rd_wait_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign hrdata = hrdata_ff;

  // Current execution priority and candidate masking
  always_comb begin
    exc_prio     = active_exc_valid ? active_exc_prio : epml_pkg::PRIO_IDLE;
    nxt_cur_prio = epml_pkg::prio_min(exc_prio,
                   epml_pkg::prio_min(fault_prio, base_prio));   // RULE_13
    nxt_masked   = 1'b0;
    if (fault_on && cand_exc_prio >= fault_prio) begin          // RULE_06
      nxt_masked = 1'b1;
    end
    if (base_on && cand_exc_prio > base_prio) begin             // RULE_09
      nxt_masked = 1'b1;
    end
    if (active_exc_valid && cand_exc_prio >= active_exc_prio) begin // RULE_12
      nxt_masked = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_prio_ff <= epml_pkg::PRIO_IDLE;
      masked_ff   <= 1'b0;
    end else begin
      cur_prio_ff <= nxt_cur_prio;
      masked_ff   <= nxt_masked;
    end
  end

  assign cur_exec_prio   = cur_prio_ff;
  assign cand_exc_masked = masked_ff;

endmodule : epml_top

// ===== test/epml_chk.sv
/*
  Checker for the execution priority mask logic, bound to the top module.
  Assumes one clock domain and the bench as the single bus master.
*/
`timescale 1ns/100ps
module epml_chk (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hrdata,
  // Priorities
  input wire logic                 active_exc_valid,
  input wire epml_pkg::epml_prio_t active_exc_prio,
  input wire epml_pkg::epml_prio_t cand_exc_prio,
  input wire logic                 cand_exc_masked,
  input wire epml_pkg::epml_prio_t cur_exec_prio
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic acc;
  assign acc = hsel && htrans[1] && hready;

  property p_rd_wait; acc && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read without one wait state");
  property p_wr_ready; acc && hwrite |=> hreadyout; endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write data phase stalled");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_thr_rd;
    acc && !hwrite && haddr[7:0] == epml_pkg::OFS_BPT_S |=> ##1 (hrdata & 32'hffffff1f) == 32'h0;
  endproperty
  a_thr_rd: assert property (p_thr_rd) else $error("threshold dead bits set");
  property p_rst_idle; $fell(sys_rst) |-> cur_exec_prio == epml_pkg::PRIO_IDLE; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("priority boosted out of reset");
  property p_act_min; active_exc_valid |=> cur_exec_prio <= $past(active_exc_prio); endproperty
  a_act_min: assert property (p_act_min) else $error("active priority not applied");
  property p_cap; cur_exec_prio <= epml_pkg::PRIO_IDLE; endproperty
  a_cap: assert property (p_cap) else $error("priority above idle level");
  property p_unmasked; $past(cand_exc_prio) < cur_exec_prio |-> !cand_exc_masked; endproperty
  a_unmasked: assert property (p_unmasked) else $error("urgent candidate masked");
  property p_masked;
    !$past(sys_rst) && $past(cand_exc_prio) > cur_exec_prio |-> cand_exc_masked;
  endproperty
  a_masked: assert property (p_masked) else $error("low candidate not masked");

  c_masked: cover property (cand_exc_masked);
  c_neg3: cover property (cur_exec_prio == epml_pkg::PRIO_NEG3);
  c_rd: cover property (acc && !hwrite);
endmodule : epml_chk

bind epml_top epml_chk u_chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .active_exc_valid, .active_exc_prio, .cand_exc_prio,
  .cand_exc_masked, .cur_exec_prio);

// ===== test/epml_arb_model.sv
/*
  Model of the exception arbitration side: presents the active and the
  candidate exception priorities one cycle after the bench asks.
  Assumes the core clock and reset.
*/
`timescale 1ns/100ps
module epml_arb_model (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Bench commands
  input wire logic                 set_valid,
  input wire epml_pkg::epml_prio_t set_act,
  input wire epml_pkg::epml_prio_t set_cand,
  // Toward the mask logic
  output logic                     active_exc_valid,
  output epml_pkg::epml_prio_t     active_exc_prio,
  output epml_pkg::epml_prio_t     cand_exc_prio
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_exc_valid <= 1'b0;
      active_exc_prio  <= epml_pkg::PRIO_IDLE;
      cand_exc_prio    <= epml_pkg::PRIO_IDLE;
    end else begin
      active_exc_valid <= set_valid;
      // Priority is meaningless without valid, so it keeps changing
      active_exc_prio  <= set_valid ? set_act : ~active_exc_prio;
      cand_exc_prio    <= set_cand;
    end
  end
endmodule : epml_arb_model

// ===== test/epml_tb_top.sv
/*
  Testbench for the execution priority mask logic: bus tasks and checks.
  Assumes the checker is bound and the arbitration model drives priorities.
*/
`timescale 1ns/100ps
module epml_tb_top;
  logic                 clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, d;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic                 active_exc_valid, cand_exc_masked, set_valid;
  epml_pkg::epml_prio_t active_exc_prio, cand_exc_prio, cur_exec_prio, set_act, set_cand;
  int                   fails, checks;
  logic [2:0]           cfg_v [5] = '{3'h1, 3'h1, 3'h5, 3'h3, 3'h3};
  logic [7:0]           ofs_v [5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h04};
  epml_pkg::epml_prio_t exp_v [5] = '{10'h3ff, 10'h000, 10'h080, 10'h3fd, 10'h3ff};

  epml_top DUT (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .active_exc_valid, .active_exc_prio,
    .cand_exc_prio, .cand_exc_masked, .cur_exec_prio);
  epml_arb_model u_model (.clk, .sys_rst, .set_valid, .set_act, .set_cand,
    .active_exc_valid, .active_exc_prio, .cand_exc_prio);

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= v;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] v); xfer(1'b1, a, v); endtask : wr
  task automatic rd(input logic [7:0] a); xfer(1'b0, a, 32'h0); endtask : rd
  task automatic settle; repeat (3) @(posedge clk); endtask : settle
  task automatic cand(input epml_pkg::epml_prio_t p); set_cand <= p; settle; endtask : cand
  task automatic report(input logic ok);
    checks++;
    if (!ok) begin
      fails++;
      $display("wrong value at %0t: mismatch", $time);
    end
  endtask : report
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e); report(g === e);
  endtask : chk_word
  task automatic chk_prio(input epml_pkg::epml_prio_t e); report(cur_exec_prio === e);
  endtask : chk_prio
  task automatic chk_bit(input logic e); report(cand_exc_masked === e); endtask : chk_bit
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    fails++;
    finish_test;
  end

  initial begin
    sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; set_valid = 1'b0; set_act = 10'h100; set_cand = 10'h100;
    fails = 0; checks = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(epml_pkg::OFS_CFG); chk_word(d, 32'h0);
    rd(epml_pkg::OFS_BPT_S); chk_word(d, 32'h0);
    chk_prio(epml_pkg::PRIO_IDLE);
    $display("reset test done");
    wr(epml_pkg::OFS_FEM_NS, 32'h1); settle; chk_prio(epml_pkg::PRIO_IDLE);
    wr(epml_pkg::OFS_FEM_S, 32'hffffffff); rd(epml_pkg::OFS_FEM_S); chk_word(d, 32'h1);
    settle; chk_prio(epml_pkg::PRIO_NEG1);
    rd(epml_pkg::OFS_STAT); chk_word(d, 32'h0001_03ff);
    cand(10'h3ff); chk_bit(1'b1);
    cand(10'h3fe); chk_bit(1'b0);
    wr(epml_pkg::OFS_FEM_S, 32'h0); wr(epml_pkg::OFS_FEM_NS, 32'h0);
    $display("single fault mask test done");
    for (int i = 0; i < 5; i++) begin
      wr(epml_pkg::OFS_CFG, {29'h0, cfg_v[i]}); wr(ofs_v[i], 32'h1); settle;
      chk_prio(exp_v[i]);
      wr(ofs_v[i], 32'h0);
    end
    $display("secure fault mask test done");
    wr(epml_pkg::OFS_CFG, 32'h1); wr(epml_pkg::OFS_BPT_S, 32'hffffffff);
    rd(epml_pkg::OFS_BPT_S); chk_word(d, 32'he0);
    settle; chk_prio(10'h0e0);
    cand(10'h0e0); chk_bit(1'b0);
    cand(10'h0e1); chk_bit(1'b1);
    wr(epml_pkg::OFS_BPT_NS, 32'h40); settle; chk_prio(10'h0a0);
    rd(epml_pkg::OFS_BPT_NS); chk_word(d, 32'h40);
    rd(epml_pkg::OFS_STAT); chk_word(d, 32'h0002_00a0);
    set_valid <= 1'b1; set_act <= 10'h020; settle; chk_prio(10'h020);
    set_valid <= 1'b0; wr(epml_pkg::OFS_BPT_S, 32'h0); wr(epml_pkg::OFS_BPT_NS, 32'h0);
    settle; chk_prio(epml_pkg::PRIO_IDLE);
    rd(8'h18); chk_word(d, 32'h0);
    $display("threshold test done");
    finish_test;
  end
endmodule : epml_tb_top
